// file: irq_group_priority_arbiter.sv
// Operation
// - Two 32-bit read/write order configuration registers at their addresses, reset to zero.
// - Mode bit per group: 0 fixes requests 0 and 5, 1 rotates all six.
// - Fixed-ends two-bit code rotates middle four requests starting at 1+code.
// - Rotate-all code n of 0 to 5 puts request n first, others follow circularly; codes 6 and 7 act as code 0.
// - Group 6 mode at bit 27, order code at bits 26 to 24.
// - Group 5 mode at bit 23, order code at bits 22 to 20.
// - Group 4 mode at bit 19, order code at bits 18 to 16.
// - Group 3 mode at bit 15, order code at bits 14 to 12.
// - Group 2 mode at bit 11, order code at bits 10 to 8.
// - Group 1 mode at bit 7, order code at bits 6 to 4.
module irq_group_priority_arbiter
	import irq_order_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [5:0] grp1_req,
	input wire logic [5:0] grp2_req,
	input wire logic [5:0] grp3_req,
	input wire logic [5:0] grp4_req,
	input wire logic [5:0] grp5_req,
	input wire logic [5:0] grp6_req,
	output logic [5:0] grp1_grant,
	output logic [5:0] grp2_grant,
	output logic [5:0] grp3_grant,
	output logic [5:0] grp4_grant,
	output logic [5:0] grp5_grant,
	output logic [5:0] grp6_grant
);
	// Register and holder state
	logic [31:0] config_low_reg;
	logic [31:0] config_high_reg;
	logic [31:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// Handshake, decode and next-value nets
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic b_done;
	logic r_done;
	logic write_commit;
	logic wr_hit_low;
	logic wr_hit_high;
	logic rd_hit_low;
	logic rd_hit_high;
	logic [31:0] strb_mask;
	logic [31:0] low_merged;
	logic [31:0] high_merged;
	logic [31:0] rd_select;
	logic [1:0] rd_resp;
	logic [1:0] wr_resp;
	logic [31:0] config_low_next;
	logic [31:0] config_high_next;
	logic bvalid_next;
	logic arready_next;
	logic rvalid_next;
	// Group fields
	logic group1_rotation_select;
	logic [2:0] group1_order_code;
	logic group2_rotation_select;
	logic [2:0] group2_order_code;
	logic group3_rotation_select;
	logic [2:0] group3_order_code;
	logic group4_rotation_select;
	logic [2:0] group4_order_code;
	logic group5_rotation_select;
	logic [2:0] group5_order_code;
	logic group6_rotation_select;
	logic [2:0] group6_order_code;

	// Channel handshakes and write commit
	assign aw_take = s_axi_awvalid && awready_reg;
	assign w_take = s_axi_wvalid && wready_reg;
	assign ar_take = s_axi_arvalid && arready_reg;
	assign b_done = bvalid_reg && s_axi_bready;
	assign r_done = rvalid_reg && s_axi_rready;
	assign write_commit = aw_held_reg && w_held_reg;

	// Address decode
	assign wr_hit_low = (awaddr_reg == ORDER_CONFIG_LOW_ADDR);
	assign wr_hit_high = (awaddr_reg == ORDER_CONFIG_HIGH_ADDR);
	assign rd_hit_low = (s_axi_araddr == ORDER_CONFIG_LOW_ADDR);
	assign rd_hit_high = (s_axi_araddr == ORDER_CONFIG_HIGH_ADDR);

	// Byte-lane merge of held write data
	assign strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	assign low_merged = (config_low_reg & ~strb_mask) | (wdata_reg & strb_mask);
	assign high_merged = (config_high_reg & ~strb_mask) | (wdata_reg & strb_mask);

	// Read data selection
	assign rd_select = rd_hit_low ? config_low_reg : (rd_hit_high ? config_high_reg : 32'h00000000);

	// Response codes, decode error off the map
	assign rd_resp = (rd_hit_low || rd_hit_high) ? RESP_OKAY : RESP_DECERR;
	assign wr_resp = (wr_hit_low || wr_hit_high) ? RESP_OKAY : RESP_DECERR;

	// Group fields of the low configuration register
	assign group1_rotation_select = config_low_reg[GROUP1_MODE_BIT];
	assign group1_order_code = config_low_reg[GROUP1_CODE_LSB +: ORDER_CODE_WIDTH];
	assign group2_rotation_select = config_low_reg[GROUP2_MODE_BIT];
	assign group2_order_code = config_low_reg[GROUP2_CODE_LSB +: ORDER_CODE_WIDTH];
	assign group3_rotation_select = config_low_reg[GROUP3_MODE_BIT];
	assign group3_order_code = config_low_reg[GROUP3_CODE_LSB +: ORDER_CODE_WIDTH];
	assign group4_rotation_select = config_low_reg[GROUP4_MODE_BIT];
	assign group4_order_code = config_low_reg[GROUP4_CODE_LSB +: ORDER_CODE_WIDTH];
	assign group5_rotation_select = config_low_reg[GROUP5_MODE_BIT];
	assign group5_order_code = config_low_reg[GROUP5_CODE_LSB +: ORDER_CODE_WIDTH];
	assign group6_rotation_select = config_low_reg[GROUP6_MODE_BIT];
	assign group6_order_code = config_low_reg[GROUP6_CODE_LSB +: ORDER_CODE_WIDTH];

	// Configuration next values, unstrobed bytes kept
	assign config_low_next = (write_commit && wr_hit_low) ? low_merged : config_low_reg;
	assign config_high_next = (write_commit && wr_hit_high) ? high_merged : config_high_reg;

	// Write response stands until bready
	assign bvalid_next = write_commit ? 1'b1 : (b_done ? 1'b0 : bvalid_reg);

	// Read channel, one read in flight
	assign arready_next = ar_take ? 1'b0 : (r_done ? 1'b1 : arready_reg);
	assign rvalid_next = ar_take ? 1'b1 : (r_done ? 1'b0 : rvalid_reg);

	// Write address capture
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			awaddr_reg <= 32'h00000000;
			aw_held_reg <= 1'b0;
			awready_reg <= 1'b1;
		end else begin
			if (aw_take) begin
				awaddr_reg <= s_axi_awaddr;
				aw_held_reg <= 1'b1;
				awready_reg <= 1'b0;
			end else if (write_commit) begin
				aw_held_reg <= 1'b0;
			end
			if (b_done) begin
				awready_reg <= 1'b1;
			end
		end
	end

	// Write data capture
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			w_held_reg <= 1'b0;
			wready_reg <= 1'b1;
		end else begin
			if (w_take) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				w_held_reg <= 1'b1;
				wready_reg <= 1'b0;
			end else if (write_commit) begin
				w_held_reg <= 1'b0;
			end
			if (b_done) begin
				wready_reg <= 1'b1;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			config_low_reg <= ORDER_CONFIG_LOW_RESET;
			config_high_reg <= ORDER_CONFIG_HIGH_RESET;
		end else begin
			config_low_reg <= config_low_next;
			config_high_reg <= config_high_next;
		end
	end

	// Write response
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			bvalid_reg <= bvalid_next;
			if (write_commit) begin
				bresp_reg <= wr_resp;
			end
		end
	end

	// Read channel
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else begin
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= rd_select;
				rresp_reg <= rd_resp;
			end
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Group 1 arbiter
	group_arbiter u_group1 (
		.mclk(mclk),
		.rstn(rstn),
		.req(grp1_req),
		.rotate_select(group1_rotation_select),
		.order_code(group1_order_code),
		.grant_reg(grp1_grant)
	);

	// Group 2 arbiter
	group_arbiter u_group2 (
		.mclk(mclk),
		.rstn(rstn),
		.req(grp2_req),
		.rotate_select(group2_rotation_select),
		.order_code(group2_order_code),
		.grant_reg(grp2_grant)
	);

	// Group 3 arbiter
	group_arbiter u_group3 (
		.mclk(mclk),
		.rstn(rstn),
		.req(grp3_req),
		.rotate_select(group3_rotation_select),
		.order_code(group3_order_code),
		.grant_reg(grp3_grant)
	);

	// Group 4 arbiter
	group_arbiter u_group4 (
		.mclk(mclk),
		.rstn(rstn),
		.req(grp4_req),
		.rotate_select(group4_rotation_select),
		.order_code(group4_order_code),
		.grant_reg(grp4_grant)
	);

	// Group 5 arbiter
	group_arbiter u_group5 (
		.mclk(mclk),
		.rstn(rstn),
		.req(grp5_req),
		.rotate_select(group5_rotation_select),
		.order_code(group5_order_code),
		.grant_reg(grp5_grant)
	);

	// Group 6 arbiter
	group_arbiter u_group6 (
		.mclk(mclk),
		.rstn(rstn),
		.req(grp6_req),
		.rotate_select(group6_rotation_select),
		.order_code(group6_order_code),
		.grant_reg(grp6_grant)
	);
endmodule : irq_group_priority_arbiter

// file: irq_order_pkg.sv
package irq_order_pkg;
	// Register byte addresses and reset values
	localparam logic [31:0] ORDER_CONFIG_LOW_ADDR = 32'h4A000030;
	localparam logic [31:0] ORDER_CONFIG_HIGH_ADDR = 32'h4A000070;
	localparam logic [31:0] ORDER_CONFIG_LOW_RESET = 32'h00000000;
	localparam logic [31:0] ORDER_CONFIG_HIGH_RESET = 32'h00000000;
	// Field positions in the low configuration register
	localparam int GROUP6_MODE_BIT = 27;
	localparam int GROUP6_CODE_LSB = 24;
	localparam int GROUP5_MODE_BIT = 23;
	localparam int GROUP5_CODE_LSB = 20;
	localparam int GROUP4_MODE_BIT = 19;
	localparam int GROUP4_CODE_LSB = 16;
	localparam int GROUP3_MODE_BIT = 15;
	localparam int GROUP3_CODE_LSB = 12;
	localparam int GROUP2_MODE_BIT = 11;
	localparam int GROUP2_CODE_LSB = 8;
	localparam int GROUP1_MODE_BIT = 7;
	localparam int GROUP1_CODE_LSB = 4;
	localparam int ORDER_CODE_WIDTH = 3;
	// Arbiter shape and mode encodings
	localparam int GROUP_REQS = 6;
	localparam logic MODE_FIXED_ENDS = 1'b0;
	localparam logic MODE_ROTATE_ALL = 1'b1;
	localparam logic [2:0] ROTATE_LAST_CODE = 3'h5;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : irq_order_pkg

// file: group_arbiter.sv
module group_arbiter
	import irq_order_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [5:0] req,
	input wire logic rotate_select,
	input wire logic [2:0] order_code,
	output logic [5:0] grant_reg
);
	logic [5:0] grant_next;

	// Request index that sits at a given rank of the chosen order
	function automatic logic [2:0] order_index(input logic rot, input logic [2:0] code, input logic [2:0] rank);
		logic [3:0] sum;
		sum = {1'b0, code} + {1'b0, rank};
		if (rot == MODE_ROTATE_ALL) begin
			if (code > ROTATE_LAST_CODE) begin
				order_index = rank;
			end else if (sum >= 4'h6) begin
				order_index = 3'(sum - 4'h6);
			end else begin
				order_index = sum[2:0];
			end
		end else if (rank == 3'h0 || rank == 3'h5) begin
			order_index = rank;
		end else begin
			order_index = 3'({1'b0, 2'(rank[1:0] - 2'h1 + code[1:0])} + 3'h1);
		end
	endfunction : order_index

	// Highest ranked asserted request wins
	always_comb begin
		logic found;
		logic [2:0] idx;
		found = 1'b0;
		idx = 3'h0;
		grant_next = 6'h00;
		for (int k = 0; k < GROUP_REQS; k++) begin
			idx = order_index(rotate_select, order_code, 3'(k));
			if (!found && req[idx]) begin
				grant_next[idx] = 1'b1;
				found = 1'b1;
			end
		end
	end

	// Registered one-hot grant
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			grant_reg <= 6'h00;
		end else begin
			grant_reg <= grant_next;
		end
	end
endmodule : group_arbiter

// file: irq_req_source.sv
module irq_req_source (
	input wire logic mclk,
	input wire logic [5:0] pattern,
	output logic [5:0] grp1_req,
	output logic [5:0] grp2_req,
	output logic [5:0] grp3_req,
	output logic [5:0] grp4_req,
	output logic [5:0] grp5_req,
	output logic [5:0] grp6_req
);
	timeunit 1ns;
	timeprecision 1ns;
	// Sources raise their lines one edge after the pattern is chosen
	always_ff @(posedge mclk) begin
		grp1_req <= pattern;
		grp2_req <= pattern;
		grp3_req <= pattern;
		grp4_req <= pattern;
		grp5_req <= pattern;
		grp6_req <= pattern;
	end
endmodule : irq_req_source

// file: irq_order_checker.sv
module irq_order_checker (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [5:0] grp1_req,
	input wire logic [5:0] grp1_grant,
	input wire logic [5:0] grp6_req,
	input wire logic [5:0] grp6_grant
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Bus answers and holds
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
	a_wresp: assert property (p_wresp) else $error("no write response");
	property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rresp: assert property (p_rresp) else $error("no read response");
	property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_busy: assert property (p_busy) else $error("write taken while busy");
	// Grant shape and cause
	property p_one1; $onehot0(grp1_grant); endproperty
	a_one1: assert property (p_one1) else $error("grant not one-hot");
	property p_sub1; 1'b1 |=> (grp1_grant & ~$past(grp1_req)) == 6'h00; endproperty
	a_sub1: assert property (p_sub1) else $error("grant without request");
	property p_live6; |grp6_req |=> |grp6_grant; endproperty
	a_live6: assert property (p_live6) else $error("request not granted");
endmodule : irq_order_checker

bind irq_group_priority_arbiter irq_order_checker chk (.*);

// file: irq_group_priority_arbiter_test.sv
module irq_group_priority_arbiter_test
	import irq_order_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [5:0] pattern = '0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [5:0] grp1_req, grp2_req, grp3_req, grp4_req, grp5_req, grp6_req;
	wire [5:0] grp1_grant, grp2_grant, grp3_grant, grp4_grant, grp5_grant, grp6_grant;
	wire [35:0] grants = {grp6_grant, grp5_grant, grp4_grant, grp3_grant, grp2_grant, grp1_grant};
	int num_errors = 0, tests_run = 0, cyc = 0;
	logic [5:0] pats [5] = '{6'h3F, 6'h3E, 6'h1C, 6'h21, 6'h00};

	initial forever #10 mclk = ~mclk;
	irq_group_priority_arbiter dut (.*);
	irq_req_source src (.*);

	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			end_sim;
		end
	end

	task chk_data(input logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t data %h exp %h", $time, g, e);
		end
	endtask : chk_data

	task chk_grant(input logic [5:0] g, e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t grant %b exp %b", $time, g, e);
		end
	endtask : chk_grant

	task chk_resp(input logic [1:0] g, e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t resp %b exp %b", $time, g, e);
		end
	endtask : chk_resp

	// Bus write: address and data together, response held until seen
	task wr(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		@(posedge mclk);
		while (s_axi_awvalid || s_axi_wvalid || s_axi_bready) begin
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bready && s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				r = s_axi_bresp;
			end
			@(posedge mclk);
		end
	endtask : wr

	task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge mclk);
		while (s_axi_arvalid || s_axi_rready) begin
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rready && s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
			@(posedge mclk);
		end
	endtask : rd

	// Winner of a request set under one group field
	function automatic logic [5:0] exp_grant(input logic [3:0] f, input logic [5:0] q);
		int i;
		exp_grant = 6'h00;
		for (int k = 5; k >= 0; k--) begin
			if (f[3]) i = (f[2:0] < 3'h6) ? (f[2:0] + k) % 6 : k;
			else i = (k == 0 || k == 5) ? k : 1 + (k + 3 + f[1:0]) % 4;
			if (q[i]) exp_grant = 6'h01 << i;
		end
	endfunction : exp_grant

	task end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	// Main sequence
	initial begin
		logic [31:0] cfg, d;
		logic [1:0] r;
		logic [3:0] f;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rd(ORDER_CONFIG_LOW_ADDR, d, r);
		chk_data(d, ORDER_CONFIG_LOW_RESET);
		chk_resp(r, RESP_OKAY);
		rd(ORDER_CONFIG_HIGH_ADDR, d, r);
		chk_data(d, ORDER_CONFIG_HIGH_RESET);
		wr(ORDER_CONFIG_HIGH_ADDR, 32'hFFFFFFFF, 4'hF, r);
		chk_resp(r, RESP_OKAY);
		wr(ORDER_CONFIG_HIGH_ADDR, 32'h12345678, 4'h5, r);
		rd(ORDER_CONFIG_HIGH_ADDR, d, r);
		chk_data(d, 32'hFF34FF78);
		wr(32'h4A000034, 32'hFFFFFFFF, 4'hF, r);
		chk_resp(r, RESP_DECERR);
		rd(32'h4A000034, d, r);
		chk_resp(r, RESP_DECERR);
		chk_data(d, 32'h00000000);
		$display("test registers done");
		for (int c = 0; c < 16; c++) begin
			cfg = '0;
			for (int g = 1; g <= 6; g++) begin
				f = 4'(c + g);
				if (!f[3]) f[2] = 1'b0;
				cfg[4*g +: 4] = f;
			end
			wr(ORDER_CONFIG_LOW_ADDR, cfg, 4'hF, r);
			chk_resp(r, RESP_OKAY);
			rd(ORDER_CONFIG_LOW_ADDR, d, r);
			chk_data(d, cfg);
			foreach (pats[p]) begin
				pattern <= pats[p];
				repeat (3) @(posedge mclk);
				for (int g = 1; g <= 6; g++) chk_grant(grants[6*g-6 +: 6], exp_grant(cfg[4*g +: 4], pats[p]));
			end
		end
		$display("test orders done");
		end_sim;
	end
endmodule : irq_group_priority_arbiter_test
